// ===== verilog/mcuad_cfg.svh
`ifndef MCUAD_CFG_SVH
`define MCUAD_CFG_SVH

// ============================================================
// Address map boundaries (CPU byte addresses)
`define MCUAD_IO_LAST       16'h003f
`define MCUAD_RAM_FIRST     16'h0080
`define MCUAD_RAM_LAST      16'h00ff
`define MCUAD_FLASH_FIRST   16'h7800
`define MCUAD_FLASH_LAST    16'h7fee
`define MCUAD_TRIM_ADDR     16'h7fef
`define MCUAD_ROM_FIRST     16'hf000
`define MCUAD_ROM_LAST      16'hf2ef
`define MCUAD_HIGH_FIRST    16'hfe00
`define MCUAD_HIGH_LAST     16'hfe0f
`define MCUAD_RESV_FIRST    16'hfe03
`define MCUAD_RESV_LAST     16'hfe06
`define MCUAD_RESV_SINGLE   16'hfe09

// ============================================================
// Register offsets
`define MCUAD_PORTA_DATA    16'h0000
`define MCUAD_PORTB_DATA    16'h0001
`define MCUAD_PORTA_DIR     16'h0004
`define MCUAD_PORTB_DIR     16'h0005
`define MCUAD_IRQKB_SC      16'h001a
`define MCUAD_KB_ENABLES    16'h001b
`define MCUAD_CONFIG        16'h001f
`define MCUAD_BRK_STATUS    16'hfe00
`define MCUAD_RST_SOURCE    16'hfe01
`define MCUAD_BRK_FLAGCTL   16'hfe02
`define MCUAD_FLASH_CTL     16'hfe08
`define MCUAD_BRKPT_HIGH    16'hfe0c
`define MCUAD_BRKPT_LOW     16'hfe0d
`define MCUAD_BRKPT_SC      16'hfe0e
`define MCUAD_LV_STATUS     16'hfe0f
`define MCUAD_FLASH_PROT    16'hfff0
`define MCUAD_WDOG_CTL      16'hffff

// ============================================================
// Field positions and reset values
`define MCUAD_IRQ_FLAG_BIT  3'd7
`define MCUAD_IRQ_ACK_BIT   3'd6
`define MCUAD_IRQ_MASK_BIT  3'd5
`define MCUAD_IRQ_MODE_BIT  3'd4
`define MCUAD_KEY_FLAG_BIT  3'd3
`define MCUAD_KEY_ACK_BIT   3'd2
`define MCUAD_KEY_MASK_BIT  3'd1
`define MCUAD_KEY_MODE_BIT  3'd0
`define MCUAD_DIRB_MASK     8'h8f
`define MCUAD_KBIE_MASK     8'h7e
`define MCUAD_CONFIG_RESET  8'h30
`define MCUAD_HIGH_ENTRIES  8

`endif

// ===== verilog/mcuad_pkg.sv
package mcuad_pkg;

  typedef enum logic [3:0] {
    MCUAD_NONE,
    MCUAD_IO_INT,
    MCUAD_IO_EXT,
    MCUAD_RAM,
    MCUAD_FLASH,
    MCUAD_TRIM,
    MCUAD_ROM,
    MCUAD_HIGH,
    MCUAD_RESERVED,
    MCUAD_ILLEGAL
  } mcuad_region_t;

  typedef enum logic [1:0] {
    MCUAD_IDLE,
    MCUAD_ACCESS,
    MCUAD_DONE
  } mcuad_state_t;

endpackage

// ===== verilog/mcuad_address_decoder.sv
`include "mcuad_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module mcuad_address_decoder (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Avalon-MM slave
  input  wire logic [17:0]            address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // Memory and peripheral side
  output mcuad_pkg::mcuad_region_t    regionSelect,
  output logic      [15:0]            memAddress,
  output logic                        memRead,
  output logic                        memWrite,
  output logic      [7:0]             memWriteData,
  input  wire logic [7:0]             memReadData,
  output logic                        illegalAddressReset,
  // Status inputs from system logic
  input  wire logic [7:0]             resetSourceIn,
  input  wire logic [7:0]             lowVoltageIn,
  input  wire logic                   extIrqEvent,
  input  wire logic                   keypadEvent,
  // Port pins
  input  wire logic [7:0]             portAPin,
  input  wire logic [3:0]             portBPin,
  output logic      [7:0]             portAPinValues,
  output logic      [7:0]             portADirection,
  output logic      [3:0]             portBPinValues,
  output logic      [3:0]             portBDirection,
  output logic                        clockOutputEnable,
  // Interrupt control
  output logic                        externalPinIrqFlag,
  output logic                        externalPinIrqMask,
  output logic                        externalPinTriggerMode,
  output logic                        keypadFlag,
  output logic                        keypadIrqMask,
  output logic                        keypadTriggerMode,
  output logic      [6:1]             keypadPinEnable,
  output logic      [7:0]             configValue
);

  // ============================================================
  // State
  typedef struct packed {
    mcuad_pkg::mcuad_state_t  state;
    logic                     wait_;
    logic [7:0]               rdata;
    mcuad_pkg::mcuad_region_t region;
    logic [15:0]              memAddr;
    logic                     memRd;
    logic                     memWr;
    logic [7:0]               memWdata;
    logic                     illegal;
    logic [7:0]               dirA;
    logic [7:0]               dirB;
    logic [7:0]               irqKb;
    logic [7:0]               kbEn;
    logic [7:0]               cfg;
    logic [`MCUAD_HIGH_ENTRIES-1:0][7:0] high;
    logic [7:0]               pinA1;
    logic [7:0]               pinA2;
    logic [3:0]               pinB1;
    logic [3:0]               pinB2;
  } mcuad_regs_t;

  mcuad_regs_t s;
  mcuad_regs_t next_s;

  // Port data and RAM keep their contents over reset, so they live
  // outside the reset struct.
  logic [7:0]       portA;
  logic [3:0]       portB;
  logic [7:0]       ram [0:127];

  logic [15:0]      cpuAddr;
  logic             doWrite;
  logic [7:0]       wbyte;
  mcuad_pkg::mcuad_region_t reg_;

  // Byte addresses on a word grid: each CPU byte owns one bus word,
  // so the two low address bits carry no meaning here.
  assign cpuAddr = address[17:2];
  assign wbyte   = writedata[7:0];
  assign doWrite = (s.state == mcuad_pkg::MCUAD_DONE) && write &&
                   byteenable[0];

  // ============================================================
  // Decode
  // High-page storage is a compact table; FE01 and FE0F only mirror
  // system inputs and get no slot, so they map to the 4'hf marker.
  function automatic logic [3:0] highIndex(input logic [15:0] a);
    logic [3:0] i;
    i = 4'h0;
    case (a)
      `MCUAD_BRK_STATUS:  i = 4'h0;
      `MCUAD_BRK_FLAGCTL: i = 4'h1;
      `MCUAD_FLASH_CTL:   i = 4'h2;
      `MCUAD_BRKPT_HIGH:  i = 4'h3;
      `MCUAD_BRKPT_LOW:   i = 4'h4;
      `MCUAD_BRKPT_SC:    i = 4'h5;
      `MCUAD_FLASH_PROT:  i = 4'h6;
      `MCUAD_WDOG_CTL:    i = 4'h7;
      default:            i = 4'hf;
    endcase
    return i;
  endfunction

  always_comb
  begin
    reg_ = mcuad_pkg::MCUAD_ILLEGAL;
    if (cpuAddr <= `MCUAD_IO_LAST)
    begin
      case (cpuAddr)
        `MCUAD_PORTA_DATA, `MCUAD_PORTB_DATA,
        `MCUAD_PORTA_DIR, `MCUAD_PORTB_DIR,
        `MCUAD_IRQKB_SC, `MCUAD_KB_ENABLES,
        `MCUAD_CONFIG:
          reg_ = mcuad_pkg::MCUAD_IO_INT;
        default:
          // Gaps below 0020 stay illegal; the rest is peripherals
          if (cpuAddr[5])
            reg_ = mcuad_pkg::MCUAD_IO_EXT;
          else
            reg_ = mcuad_pkg::MCUAD_ILLEGAL;
      endcase
    end
    else if (cpuAddr >= `MCUAD_RAM_FIRST && cpuAddr <= `MCUAD_RAM_LAST)
      reg_ = mcuad_pkg::MCUAD_RAM;
    else if (cpuAddr >= `MCUAD_FLASH_FIRST &&
             cpuAddr <= `MCUAD_FLASH_LAST)
      reg_ = mcuad_pkg::MCUAD_FLASH;
    else if (cpuAddr == `MCUAD_TRIM_ADDR)
      reg_ = mcuad_pkg::MCUAD_TRIM;
    else if (cpuAddr >= `MCUAD_ROM_FIRST && cpuAddr <= `MCUAD_ROM_LAST)
      reg_ = mcuad_pkg::MCUAD_ROM;
    else if (cpuAddr >= `MCUAD_HIGH_FIRST &&
             cpuAddr <= `MCUAD_HIGH_LAST)
    begin
      if ((cpuAddr >= `MCUAD_RESV_FIRST &&
           cpuAddr <= `MCUAD_RESV_LAST) ||
          cpuAddr == `MCUAD_RESV_SINGLE)
        reg_ = mcuad_pkg::MCUAD_RESERVED;
      else if (highIndex(cpuAddr) != 4'hf ||
               cpuAddr == `MCUAD_RST_SOURCE ||
               cpuAddr == `MCUAD_LV_STATUS)
        reg_ = mcuad_pkg::MCUAD_HIGH;
      else
        reg_ = mcuad_pkg::MCUAD_ILLEGAL;
    end
    else if (cpuAddr == `MCUAD_FLASH_PROT || cpuAddr == `MCUAD_WDOG_CTL)
      reg_ = mcuad_pkg::MCUAD_HIGH;
    else if (cpuAddr > `MCUAD_HIGH_LAST)
      // Remainder of the top page holds vectors and other blocks
      reg_ = mcuad_pkg::MCUAD_IO_EXT;
  end

  // ============================================================
  // Internal read value
  function automatic logic [7:0] readInternal(
    input logic [15:0] a, input mcuad_regs_t r,
    input logic [7:0] pa, input logic [3:0] pb);
    logic [7:0] v;
    logic [3:0] hi;
    v  = 8'h00;
    hi = highIndex(a);
    case (a)
      // Input bits show the pin, output bits the latch
      `MCUAD_PORTA_DATA: v = (pa & r.dirA) | (r.pinA2 & ~r.dirA);
      `MCUAD_PORTB_DATA: v = {4'h0, (pb & r.dirB[3:0]) |
                              (r.pinB2 & ~r.dirB[3:0])};
      `MCUAD_PORTA_DIR:  v = r.dirA;
      `MCUAD_PORTB_DIR:  v = r.dirB & `MCUAD_DIRB_MASK;
      `MCUAD_IRQKB_SC:   v = r.irqKb;
      `MCUAD_KB_ENABLES: v = r.kbEn & `MCUAD_KBIE_MASK;
      `MCUAD_CONFIG:     v = r.cfg;
      `MCUAD_RST_SOURCE: v = resetSourceIn;
      `MCUAD_LV_STATUS:  v = lowVoltageIn;
      default:
        if (hi != 4'hf)
          v = r.high[hi[2:0]];
        else
          v = 8'h00;
    endcase
    return v;
  endfunction

  // ============================================================
  // Next state
  always_comb
  begin
    logic [3:0] hi;
    next_s         = s;
    hi             = highIndex(cpuAddr);
    next_s.pinA1   = portAPin;
    next_s.pinA2   = s.pinA1;
    next_s.pinB1   = portBPin;
    next_s.pinB2   = s.pinB1;
    next_s.memRd   = 1'b0;
    next_s.memWr   = 1'b0;
    next_s.illegal = 1'b0;
    // One access spans three edges: take, decode and fetch, complete.
    // Writes land only on the completion edge, where the master sees
    // waitrequest low, so storage never changes mid-request.
    case (s.state)
      mcuad_pkg::MCUAD_IDLE:
        if (read || write)
        begin
          next_s.state    = mcuad_pkg::MCUAD_ACCESS;
          next_s.region   = reg_;
          next_s.memAddr  = cpuAddr;
          next_s.memWdata = wbyte;
        end
      mcuad_pkg::MCUAD_ACCESS:
      begin
        next_s.state = mcuad_pkg::MCUAD_DONE;
        next_s.wait_ = 1'b0;
        case (s.region)
          mcuad_pkg::MCUAD_IO_INT, mcuad_pkg::MCUAD_HIGH:
            next_s.rdata = readInternal(cpuAddr, s, portA, portB);
          mcuad_pkg::MCUAD_RAM:
            next_s.rdata = ram[cpuAddr[6:0]];
          mcuad_pkg::MCUAD_IO_EXT, mcuad_pkg::MCUAD_FLASH,
          mcuad_pkg::MCUAD_TRIM, mcuad_pkg::MCUAD_ROM:
            next_s.rdata = memReadData;
          // The cycle still completes so a gap never hangs the master
          mcuad_pkg::MCUAD_ILLEGAL:
          begin
            next_s.rdata   = 8'h00;
            next_s.illegal = 1'b1;
          end
          default:
            next_s.rdata = 8'h00;
        endcase
      end
      mcuad_pkg::MCUAD_DONE:
      begin
        next_s.state  = mcuad_pkg::MCUAD_IDLE;
        next_s.wait_  = 1'b1;
        next_s.region = mcuad_pkg::MCUAD_NONE;
        if (s.region == mcuad_pkg::MCUAD_IO_EXT ||
            s.region == mcuad_pkg::MCUAD_FLASH ||
            s.region == mcuad_pkg::MCUAD_TRIM ||
            s.region == mcuad_pkg::MCUAD_ROM)
        begin
          // Outside strobe fires on the edge the bus completes
          next_s.memRd = read;
          next_s.memWr = doWrite;
        end
        if (doWrite && s.region == mcuad_pkg::MCUAD_IO_INT)
        begin
          case (cpuAddr)
            `MCUAD_PORTA_DIR: next_s.dirA = wbyte;
            `MCUAD_PORTB_DIR:
              next_s.dirB = wbyte & `MCUAD_DIRB_MASK;
            `MCUAD_IRQKB_SC:
            begin
              next_s.irqKb[`MCUAD_IRQ_MASK_BIT] =
                wbyte[`MCUAD_IRQ_MASK_BIT];
              next_s.irqKb[`MCUAD_IRQ_MODE_BIT] =
                wbyte[`MCUAD_IRQ_MODE_BIT];
              next_s.irqKb[`MCUAD_KEY_MASK_BIT] =
                wbyte[`MCUAD_KEY_MASK_BIT];
              next_s.irqKb[`MCUAD_KEY_MODE_BIT] =
                wbyte[`MCUAD_KEY_MODE_BIT];
              if (wbyte[`MCUAD_IRQ_ACK_BIT])
                next_s.irqKb[`MCUAD_IRQ_FLAG_BIT] = 1'b0;
              if (wbyte[`MCUAD_KEY_ACK_BIT])
                next_s.irqKb[`MCUAD_KEY_FLAG_BIT] = 1'b0;
            end
            `MCUAD_KB_ENABLES:
              next_s.kbEn = wbyte & `MCUAD_KBIE_MASK;
            `MCUAD_CONFIG: next_s.cfg = wbyte;
            default: next_s.cfg = s.cfg;
          endcase
        end
        if (doWrite && s.region == mcuad_pkg::MCUAD_HIGH &&
            hi != 4'hf)
          next_s.high[hi[2:0]] = wbyte;
      end
      default:
        next_s.state = mcuad_pkg::MCUAD_IDLE;
    endcase
    // Events set after the acknowledge so a same-cycle event wins
    if (extIrqEvent)
      next_s.irqKb[`MCUAD_IRQ_FLAG_BIT] = 1'b1;
    if (keypadEvent)
      next_s.irqKb[`MCUAD_KEY_FLAG_BIT] = 1'b1;
    next_s.irqKb[`MCUAD_IRQ_ACK_BIT] = 1'b0;
    next_s.irqKb[`MCUAD_KEY_ACK_BIT] = 1'b0;
  end

  // ============================================================
  // Registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s       <= '0;
      s.wait_ <= 1'b1;
      s.cfg   <= `MCUAD_CONFIG_RESET;
    end
    else
      s <= next_s;
  end

  // Limitation: after power-up these read unknown until written
  // No reset here: port data and RAM survive a reset
  always_ff @(posedge clock)
  begin
    if (doWrite && s.region == mcuad_pkg::MCUAD_IO_INT &&
        cpuAddr == `MCUAD_PORTA_DATA)
      portA <= wbyte;
    if (doWrite && s.region == mcuad_pkg::MCUAD_IO_INT &&
        cpuAddr == `MCUAD_PORTB_DATA)
      portB <= wbyte[3:0];
    if (doWrite && s.region == mcuad_pkg::MCUAD_RAM)
      ram[cpuAddr[6:0]] <= wbyte;
  end

  // ============================================================
  // Outputs
  assign readdata               = {24'h000000, s.rdata};
  assign waitrequest            = s.wait_;
  assign regionSelect           = s.region;
  assign memAddress             = s.memAddr;
  assign memRead                = s.memRd;
  assign memWrite               = s.memWr;
  assign memWriteData           = s.memWdata;
  assign illegalAddressReset    = s.illegal;
  assign portAPinValues         = portA;
  assign portADirection         = s.dirA;
  assign portBPinValues         = portB;
  assign portBDirection         = s.dirB[3:0];
  assign clockOutputEnable      = s.dirB[7];
  assign externalPinIrqFlag     = s.irqKb[`MCUAD_IRQ_FLAG_BIT];
  assign externalPinIrqMask     = s.irqKb[`MCUAD_IRQ_MASK_BIT];
  assign externalPinTriggerMode = s.irqKb[`MCUAD_IRQ_MODE_BIT];
  assign keypadFlag             = s.irqKb[`MCUAD_KEY_FLAG_BIT];
  assign keypadIrqMask          = s.irqKb[`MCUAD_KEY_MASK_BIT];
  assign keypadTriggerMode      = s.irqKb[`MCUAD_KEY_MODE_BIT];
  assign keypadPinEnable        = s.kbEn[6:1];
  assign configValue            = s.cfg;

endmodule // mcuad_address_decoder

`default_nettype wire

// ===== test/mcuad_ad_properties.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Decode and bus timing checks on the decoder's ports
module mcuad_ad_properties (
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // Observed outputs
  input wire logic                     waitrequest,
  input wire logic                     illegalAddressReset,
  input wire mcuad_pkg::mcuad_region_t regionSelect,
  input wire logic [15:0]              memAddress,
  input wire logic                     memRead,
  input wire logic                     memWrite,
  input wire logic [7:0]               portADirection,
  input wire logic [3:0]               portBDirection,
  input wire logic                     clockOutputEnable,
  // Interrupt event and flag
  input wire logic                     extIrqEvent,
  input wire logic                     externalPinIrqFlag
);
  logic inGap;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  assign inGap = memAddress inside {[16'h0002:16'h0003],
    [16'h0006:16'h0019], [16'h001c:16'h001e], [16'h0040:16'h007f],
    [16'h0100:16'h77ff], [16'h7ff0:16'hefff], [16'hf2f0:16'hfdff],
    16'hfe07, 16'hfe0a, 16'hfe0b};

  a_io_page: assert property (
    regionSelect == mcuad_pkg::MCUAD_IO_INT |-> memAddress <= 16'h003f)
    else $error("internal I/O select outside page");
  a_ram_window: assert property (
    regionSelect == mcuad_pkg::MCUAD_RAM |->
      memAddress inside {[16'h0080:16'h00ff]})
    else $error("RAM select outside its window");
  a_flash_window: assert property (
    regionSelect == mcuad_pkg::MCUAD_FLASH |->
      memAddress inside {[16'h7800:16'h7fee]})
    else $error("flash select outside its window");
  a_trim_byte: assert property (
    regionSelect == mcuad_pkg::MCUAD_TRIM |-> memAddress == 16'h7fef)
    else $error("trim select at wrong address");
  a_rom_window: assert property (
    regionSelect == mcuad_pkg::MCUAD_ROM |->
      memAddress inside {[16'hf000:16'hf2ef]})
    else $error("ROM select outside its window");
  a_gap_decode: assert property (
    regionSelect == mcuad_pkg::MCUAD_ILLEGAL |-> inGap)
    else $error("illegal region on an implemented address");
  a_gap_reset: assert property (
    $rose(regionSelect == mcuad_pkg::MCUAD_ILLEGAL) |=>
      illegalAddressReset && !waitrequest ##1 !illegalAddressReset)
    else $error("gap access without one reset pulse");
  a_dir_reset: assert property (
    $fell(rst) |-> portADirection == 8'h00 && portBDirection == 4'h0
      && !clockOutputEnable)
    else $error("direction bits not cleared by reset");
  a_mem_strobe: assert property (
    memRead || memWrite |-> $past(!waitrequest) &&
      $past(regionSelect) inside {mcuad_pkg::MCUAD_IO_EXT,
      mcuad_pkg::MCUAD_FLASH, mcuad_pkg::MCUAD_TRIM, mcuad_pkg::MCUAD_ROM})
    else $error("memory strobe without external access");
  a_irq_set: assert property (
    extIrqEvent |=> externalPinIrqFlag)
    else $error("IRQ event did not set its flag");

  c_gap: cover property (illegalAddressReset);
  c_ext_read: cover property (memRead);
  c_dir_reset: cover property ($fell(rst));
endmodule // mcuad_ad_properties

bind mcuad_address_decoder mcuad_ad_properties checker_u (
  .clock(clock), .rst(rst), .waitrequest(waitrequest),
  .illegalAddressReset(illegalAddressReset), .regionSelect(regionSelect),
  .memAddress(memAddress), .memRead(memRead), .memWrite(memWrite),
  .portADirection(portADirection), .portBDirection(portBDirection),
  .clockOutputEnable(clockOutputEnable), .extIrqEvent(extIrqEvent),
  .externalPinIrqFlag(externalPinIrqFlag));

`default_nettype wire

// ===== test/mcuad_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Far-side memory: answers external regions from the address
module mcuad_mem_model (
  // Clock
  input wire logic                     clock,
  // Decoder memory side
  input wire mcuad_pkg::mcuad_region_t regionSelect,
  input wire logic [15:0]              memAddress,
  output logic     [7:0]               memReadData
);
  logic [7:0] idleData = 8'h5a;
  logic       selected;

  assign selected = regionSelect inside {mcuad_pkg::MCUAD_IO_EXT,
    mcuad_pkg::MCUAD_FLASH, mcuad_pkg::MCUAD_TRIM, mcuad_pkg::MCUAD_ROM};
  // Unselected bus toggles so stale data can never pass for an answer
  always_ff @(posedge clock) idleData <= ~idleData;
  assign memReadData = selected ? (memAddress[7:0] ^ 8'ha5) : idleData;
endmodule // mcuad_mem_model

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Register map and decode bench
module testbench;
  logic        clock, rst, read, write, waitrequest, memRead, memWrite;
  logic        illegalAddressReset, extIrqEvent, keypadEvent;
  logic        clockOutputEnable, externalPinIrqFlag, keypadFlag;
  logic        lastIllegal, lastStrobe;
  logic [17:0] address;
  logic [31:0] writedata, readdata, lastData;
  logic [3:0]  byteenable, portBPin, portBPinValues;
  logic [15:0] memAddress;
  logic [7:0]  memReadData, resetSourceIn, lowVoltageIn, portAPin;
  logic [7:0]  portAPinValues, portADirection;
  logic [6:1]  keypadPinEnable;
  logic [7:0]  configValue, memWriteData;
  logic [3:0]  portBDirection;
  logic        externalPinIrqMask, externalPinTriggerMode;
  logic        keypadIrqMask, keypadTriggerMode;
  mcuad_pkg::mcuad_region_t lastRegion;
  int          fails, n_compared, cycles;
  mcuad_pkg::mcuad_region_t regionSelect;
  // Unimplemented gaps; reserved FE03-FE06 and FE09 never touched
  logic [15:0] gaps [17] = '{16'h0002, 16'h0003, 16'h0006, 16'h0019,
    16'h001c, 16'h001e, 16'h0040, 16'h007f, 16'h0100, 16'h77ff,
    16'h7ff0, 16'hefff, 16'hf2f0, 16'hfdff, 16'hfe07, 16'hfe0a, 16'hfe0b};
  logic [15:0] highs [8] = '{16'hfe00, 16'hfe02, 16'hfe08, 16'hfe0c,
    16'hfe0d, 16'hfe0e, 16'hfff0, 16'hffff};
  logic [15:0] exts [6] = '{16'h0020, 16'h7800, 16'h7fee, 16'h7fef,
    16'hf000, 16'hf2ef};
  mcuad_pkg::mcuad_region_t extKinds [6] = '{mcuad_pkg::MCUAD_IO_EXT,
    mcuad_pkg::MCUAD_FLASH, mcuad_pkg::MCUAD_FLASH, mcuad_pkg::MCUAD_TRIM,
    mcuad_pkg::MCUAD_ROM, mcuad_pkg::MCUAD_ROM};

  mcuad_address_decoder dut_u (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .regionSelect(regionSelect), .memAddress(memAddress),
    .memRead(memRead), .memWrite(memWrite),
    .memWriteData(memWriteData),
    .memReadData(memReadData), .illegalAddressReset(illegalAddressReset),
    .resetSourceIn(resetSourceIn), .lowVoltageIn(lowVoltageIn),
    .extIrqEvent(extIrqEvent), .keypadEvent(keypadEvent),
    .portAPin(portAPin), .portBPin(portBPin),
    .portAPinValues(portAPinValues), .portADirection(portADirection),
    .portBPinValues(portBPinValues), .portBDirection(portBDirection),
    .clockOutputEnable(clockOutputEnable),
    .externalPinIrqFlag(externalPinIrqFlag),
    .externalPinIrqMask(externalPinIrqMask),
    .externalPinTriggerMode(externalPinTriggerMode),
    .keypadFlag(keypadFlag), .keypadIrqMask(keypadIrqMask),
    .keypadTriggerMode(keypadTriggerMode),
    .keypadPinEnable(keypadPinEnable), .configValue(configValue));

  mcuad_mem_model model_u (.clock(clock), .regionSelect(regionSelect),
    .memAddress(memAddress), .memReadData(memReadData));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic conclude();
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic checkFlag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic busAccess(input logic wr, input logic [15:0] a,
                           input logic [7:0] d, input logic [3:0] be);
    address <= {a, 2'b00};
    writedata <= {24'h000000, d};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    // Only the global cycle ceiling ends a wait that never answers
    do
      @(posedge clock);
    while (waitrequest !== 1'b0);
    lastData = readdata;
    lastIllegal = illegalAddressReset;
    lastRegion = regionSelect;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
    lastStrobe = memRead | memWrite;
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    busAccess(1'b1, a, d, 4'h1);
  endtask

  task automatic checkRead(input logic [15:0] a, input logic [7:0] exp);
    busAccess(1'b0, a, 8'h00, 4'h1);
    checkData(lastData, {24'h000000, exp});
  endtask

  task automatic pulseEvent(input logic keypad);
    extIrqEvent <= ~keypad;
    keypadEvent <= keypad;
    @(posedge clock);
    extIrqEvent <= 1'b0;
    keypadEvent <= 1'b0;
    @(posedge clock);
  endtask

  task automatic resetPulse();
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask

  initial
  begin
    {rst, read, write, extIrqEvent, keypadEvent} = 5'h10;
    {address, writedata, byteenable} = '0;
    {fails, n_compared, cycles} = '0;
    resetSourceIn = 8'h42;
    lowVoltageIn = 8'h81;
    portAPin = 8'h00;
    portBPin = 4'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    checkRead(16'h0004, 8'h00);
    checkRead(16'h0005, 8'h00);
    checkRead(16'h001a, 8'h00);
    checkRead(16'h001b, 8'h00);
    checkRead(16'h001f, 8'h30);
    checkData({24'h000000, configValue}, 32'h00000030);
    wr8(16'h0004, 8'hff);
    busAccess(1'b1, 16'h0004, 8'h00, 4'h0);
    checkRead(16'h0004, 8'hff);
    wr8(16'h0005, 8'hff);
    checkRead(16'h0005, 8'h8f);
    checkFlag(clockOutputEnable, 1'b1);
    checkData({28'h0000000, portBDirection}, 32'h0000000f);
    wr8(16'h0000, 8'h3c);
    wr8(16'h0001, 8'hfa);
    checkRead(16'h0000, 8'h3c);
    checkRead(16'h0001, 8'h0a);
    portAPin <= 8'hc5;
    portBPin <= 4'h6;
    resetPulse();
    checkData({24'h000000, portAPinValues}, 32'h0000003c);
    checkData({28'h0000000, portBPinValues}, 32'h0000000a);
    checkData({24'h000000, portADirection}, 32'h00000000);
    checkFlag(clockOutputEnable, 1'b0);
    checkData({28'h0000000, portBDirection}, 32'h00000000);
    checkRead(16'h0000, 8'hc5);
    checkRead(16'h0001, 8'h06);
    wr8(16'h001b, 8'hff);
    checkRead(16'h001b, 8'h7e);
    checkData({26'h0000000, keypadPinEnable}, 32'h0000003f);
    wr8(16'h001a, 8'h33);
    checkRead(16'h001a, 8'h33);
    checkData({28'h0000000, externalPinIrqMask, externalPinTriggerMode,
      keypadIrqMask, keypadTriggerMode}, 32'h0000000f);
    pulseEvent(1'b0);
    checkRead(16'h001a, 8'hb3);
    checkFlag(externalPinIrqFlag, 1'b1);
    // Event held through an acknowledge: the set must win
    extIrqEvent <= 1'b1;
    wr8(16'h001a, 8'h73);
    extIrqEvent <= 1'b0;
    checkRead(16'h001a, 8'hb3);
    wr8(16'h001a, 8'h73);
    checkRead(16'h001a, 8'h33);
    pulseEvent(1'b1);
    checkRead(16'h001a, 8'h3b);
    wr8(16'h001a, 8'h37);
    checkRead(16'h001a, 8'h33);
    checkFlag(keypadFlag, 1'b0);
    foreach (gaps[i])
    begin
      checkRead(gaps[i], 8'h00);
      checkFlag(lastIllegal, 1'b1);
    end
    foreach (highs[i])
    begin
      wr8(highs[i], 8'h5a ^ 8'(i));
      checkRead(highs[i], 8'h5a ^ 8'(i));
      checkFlag(lastIllegal, 1'b0);
    end
    checkRead(16'hfe01, 8'h42);
    checkRead(16'hfe0f, 8'h81);
    foreach (exts[i])
    begin
      checkRead(exts[i], exts[i][7:0] ^ 8'ha5);
      checkFlag(lastStrobe, 1'b1);
      checkData(32'(lastRegion), 32'(extKinds[i]));
    end
    wr8(16'h0080, 8'h11);
    wr8(16'h00ff, 8'h22);
    checkRead(16'h0080, 8'h11);
    checkRead(16'h00ff, 8'h22);
    checkFlag(lastIllegal, 1'b0);
    wr8(16'h7800, 8'h96);
    checkFlag(lastStrobe, 1'b1);
    checkData({24'h000000, memWriteData}, 32'h00000096);
    wr8(16'h0040, 8'h00);
    checkFlag(lastIllegal, 1'b1);
    wr8(16'h001f, 8'h0c);
    checkRead(16'h001f, 8'h0c);
    checkData({24'h000000, configValue}, 32'h0000000c);
    conclude();
  end
endmodule // testbench

`default_nettype wire
